/* File: hdl/comp_device.sv */
// Overview of operation
// [RQ1] Span mode multiplies compensation resistor by gain one.
// [RQ2] Doublebridge uses gain one, then gain two.
// [RQ3] Span gains are unsigned 8.16 fixed point.
// [RQ4] Zero gain removes compensation resistor effect.
// [RQ5] Temperature mode uses temperature, not resistor.
// [RQ6] Temperature mode multiplies by one plus-minus term.
// [RQ7] Per bridge sign bit selects add or subtract.
// [RQ8] Resistor ratio stored into temperature register.
// [RQ9] Offset is signed 16.8 ppm value.
// [RQ10] Host calibrates offset with neutral gains.
// [RQ11] Two unsigned 8.16 scale factors exist.
// [RQ12] Scale enables at word0 bit17, word8 bit0.
// [RQ13] Single bridge scales halfbridge one, two.
// [RQ14] Halfbridge scaling happens before combination.
// [RQ15] Doublebridge scales fullbridge one, two.
// [RQ16] Uncombined halfbridges share fullbridge factor.
// [RQ17] Host sets coin cell averaging, cycle fields.
// [RQ18] Range one limits raw counts to 2^20.
// [RQ19] Reference select picks slow or fast clock.
// [RQ20] Host sets capacitance averaging, gain correction.
// [RQ21] Host sets load start bits for capacitance.
// [RQ22] Cleared enable passes result unscaled.
`timescale 1ns/100ps
`default_nettype none
module comp_device
    import comp_pkg::*;
(
    input wire logic aclk,
    comp_if.device bus,
    output logic cycle_reference_select,
    output logic load_start_bit,
    output logic load_start_delay_bit,
    output logic busy
);
    typedef enum logic [1:0] {IDLE, CALC, DONE} calc_state_t;

    logic [31:0] cfg0_ff, cfg2_ff, cfg8_ff, cfg10_ff;
    logic [23:0] span_gain_first_ff, span_gain_second_ff;
    logic [23:0] bridge_offset_value_ff, scale_factor_first_ff, scale_factor_second_ff;
    logic [31:0] raw_ff [4];
    logic [23:0] rtemp_ff, rcomp_ff;
    logic [31:0] res_ff [4];
    logic [31:0] temp_res_ff;
    logic range_err_ff;
    calc_state_t state_ff;
    logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
    logic [6:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic start_ff;

    // Multiply a signed value by an unsigned 8.16 factor and drop the fraction.
    function automatic logic signed [31:0] mul816(input logic signed [31:0] v,
                                                   input logic [23:0] f);
        logic signed [56:0] p;
        p = v * $signed({1'b0, f});
        return p[47:16];
    endfunction

    // Apply scaling only when enabled.
    function automatic logic signed [31:0] scale(input logic signed [31:0] v,
                                                  input logic [23:0] f, input logic en);
        return en ? mul816(v, f) : v; // [RQ22]
    endfunction

    wire span_res = cfg10_ff[CFG10_RSPAN_BIT];
    wire span_by_t = cfg10_ff[CFG10_SPANBYT_BIT];
    wire dbl = cfg10_ff[CFG10_DOUBLE_BIT];
    wire sum_c = cfg10_ff[CFG10_SUM_BIT];
    wire diff_c = cfg10_ff[CFG10_DIFF_BIT];
    wire combine = sum_c | diff_c;
    wire offsub = cfg10_ff[CFG10_OFFSUB_BIT];
    wire en1 = cfg0_ff[CFG0_SCALE_EN_BIT]; // [RQ12]
    wire en2 = cfg8_ff[CFG8_SCALE2_EN_BIT]; // [RQ12]
    // Raw counts above the converter's range are flagged.
    wire [3:0] over;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_over
            assign over[gi] = |raw_ff[gi][31:RANGE1_BITS]; // [RQ18]
        end
    endgenerate

    // Per-bridge span correction.
    function automatic logic signed [31:0] span(input logic signed [31:0] v,
                                                 input logic [23:0] g, input logic neg);
        logic [47:0] t;
        logic signed [31:0] k;
        logic [23:0] eff_r;
        t = 48'h0;
        k = 32'sh0;
        eff_r = 24'h0;
        if (span_res && span_by_t) begin
            t = g * rtemp_ff; // [RQ5] [RQ3]
            k = neg ? $signed(32'(GAIN_ONE)) - $signed({8'h0, t[39:16]})
                    : $signed(32'(GAIN_ONE)) + $signed({8'h0, t[39:16]}); // [RQ6] [RQ7]
            return mul816(v, k[23:0]);
        end else if (span_res) begin
            t = g * rcomp_ff; // [RQ1] [RQ3]
            eff_r = t[39:16]; // [RQ4]
            k = neg ? $signed(32'(GAIN_ONE)) - $signed({8'h0, eff_r})
                    : $signed(32'(GAIN_ONE)) + $signed({8'h0, eff_r}); // [RQ7]
            return mul816(v, k[23:0]);
        end
        return v;
    endfunction

    logic signed [31:0] s0, s1, s2, s3, fb1, fb2, offs;
    always_comb begin
        offs = offsub ? $signed({{8{bridge_offset_value_ff[23]}}, bridge_offset_value_ff})
                        >>> OFFS_FRAC_BITS : 32'sh0; // [RQ9]
        if (!dbl) begin
            s0 = scale(raw_ff[0], scale_factor_first_ff, en1); // [RQ13]
            s1 = scale(raw_ff[1], scale_factor_second_ff, en2); // [RQ13]
            s2 = 32'sh0;
            s3 = 32'sh0;
        end else begin
            s0 = scale(raw_ff[0], scale_factor_first_ff, en1); // [RQ15] [RQ16]
            s1 = scale(raw_ff[1], scale_factor_first_ff, en1); // [RQ16]
            s2 = scale(raw_ff[2], scale_factor_second_ff, en2); // [RQ15] [RQ16]
            s3 = scale(raw_ff[3], scale_factor_second_ff, en2); // [RQ16]
        end
        fb1 = sum_c ? s0 + s1 : s0 - s1; // [RQ14]
        fb2 = sum_c ? s2 + s3 : s2 - s3; // [RQ14]
        fb1 = span(fb1, span_gain_first_ff, cfg10_ff[CFG10_SIGN1_BIT]) - offs; // [RQ1]
        fb2 = span(fb2, span_gain_second_ff, cfg10_ff[CFG10_SIGN2_BIT]) - offs; // [RQ2]
    end

    // Ratio (Rcomp + Rsg)/Rsg, with Rsg normalised to 1.0.
    wire [31:0] ratio = {8'h0, rcomp_ff} + {8'h0, GAIN_ONE};

    always_ff @(posedge aclk) begin
        if (!bus.aresetn) begin
            state_ff <= IDLE;
            res_ff <= '{default: RESET_ZERO};
            temp_res_ff <= RESET_ZERO;
            range_err_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                IDLE: if (start_ff) state_ff <= CALC;
                CALC: begin
                    range_err_ff <= |over;
                    if (combine) begin
                        res_ff[0] <= fb1;
                        res_ff[1] <= dbl ? fb2 : 32'h0;
                        res_ff[2] <= 32'h0;
                        res_ff[3] <= 32'h0;
                    end else begin
                        res_ff[0] <= s0;
                        res_ff[1] <= s1;
                        res_ff[2] <= s2;
                        res_ff[3] <= s3;
                    end
                    if (span_res && !span_by_t)
                        temp_res_ff <= ratio; // [RQ8]
                    else
                        temp_res_ff <= {8'h0, rtemp_ff};
                    state_ff <= DONE;
                end
                DONE: state_ff <= IDLE;
            endcase
        end
    end

    assign busy = state_ff != IDLE;
    assign cycle_reference_select = cfg10_ff[CFG10_HS_REF_BIT]; // [RQ19]
    assign load_start_bit = cfg10_ff[CFG10_LOAD_START_BIT];
    assign load_start_delay_bit = cfg10_ff[CFG10_LOAD_DEL_BIT];

    // Write channel: address and data may arrive in any order.
    wire do_write = aw_got_ff && w_got_ff && !bvalid_ff;
    wire [4:0] widx = awaddr_ff[6:2];
    assign bus.awready = !aw_got_ff && !bvalid_ff;
    assign bus.wready = !w_got_ff && !bvalid_ff;
    assign bus.bvalid = bvalid_ff;
    assign bus.bresp = bresp_ff;
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
        for (int i = 0; i < 4; i++) if (s[i]) o[8*i +: 8] = n[8*i +: 8];
        return o;
    endfunction
    logic [3:0] wstrb_ff;
    wire wmapped = widx[4] == 1'b0;

    always_ff @(posedge aclk) begin
        if (!bus.aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            awaddr_ff <= 7'h00;
            wdata_ff <= RESET_ZERO;
            wstrb_ff <= 4'h0;
            start_ff <= 1'b0;
            cfg0_ff <= RESET_ZERO;
            cfg2_ff <= RESET_ZERO;
            cfg8_ff <= RESET_ZERO;
            cfg10_ff <= RESET_ZERO;
            span_gain_first_ff <= GAIN_ONE;
            span_gain_second_ff <= GAIN_ONE;
            bridge_offset_value_ff <= 24'h000000;
            scale_factor_first_ff <= GAIN_ONE;
            scale_factor_second_ff <= GAIN_ONE;
            raw_ff <= '{default: RESET_ZERO};
            rtemp_ff <= 24'h000000;
            rcomp_ff <= 24'h000000;
        end else begin
            start_ff <= 1'b0;
            if (bus.awvalid && bus.awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= bus.awaddr;
            end
            if (bus.wvalid && bus.wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= bus.wdata;
                wstrb_ff <= bus.wstrb;
            end
            if (bvalid_ff && bus.bready) bvalid_ff <= 1'b0;
            if (do_write) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wmapped ? RESP_OKAY : RESP_SLVERR;
                if (wmapped) begin
                    unique case (widx[3:0])
                        IDX_CFG0: cfg0_ff <= merge(cfg0_ff, wdata_ff, wstrb_ff);
                        IDX_START: start_ff <= wdata_ff[0] & wstrb_ff[0];
                        IDX_CFG2: cfg2_ff <= merge(cfg2_ff, wdata_ff, wstrb_ff);
                        IDX_BRIDGE_OFFSET: bridge_offset_value_ff <=
                            merge({8'h0, bridge_offset_value_ff}, wdata_ff, wstrb_ff)[23:0];
                        IDX_SCALE_FIRST: scale_factor_first_ff <=
                            merge({8'h0, scale_factor_first_ff}, wdata_ff, wstrb_ff)[23:0];
                        IDX_SCALE_SECOND: scale_factor_second_ff <=
                            merge({8'h0, scale_factor_second_ff}, wdata_ff, wstrb_ff)[23:0];
                        IDX_RAW_HB1: raw_ff[0] <= merge(raw_ff[0], wdata_ff, wstrb_ff);
                        IDX_RAW_HB2: raw_ff[1] <= merge(raw_ff[1], wdata_ff, wstrb_ff);
                        IDX_CFG8: cfg8_ff <= merge(cfg8_ff, wdata_ff, wstrb_ff);
                        IDX_RAW_HB3: raw_ff[2] <= merge(raw_ff[2], wdata_ff, wstrb_ff);
                        IDX_CFG10: cfg10_ff <= merge(cfg10_ff, wdata_ff, wstrb_ff);
                        IDX_RAW_HB4: raw_ff[3] <= merge(raw_ff[3], wdata_ff, wstrb_ff);
                        IDX_RTEMP: rtemp_ff <= merge({8'h0, rtemp_ff}, wdata_ff, wstrb_ff)[23:0];
                        IDX_RCOMP: rcomp_ff <= merge({8'h0, rcomp_ff}, wdata_ff, wstrb_ff)[23:0];
                        IDX_SPAN_GAIN_FIRST: span_gain_first_ff <=
                            merge({8'h0, span_gain_first_ff}, wdata_ff, wstrb_ff)[23:0];
                        IDX_SPAN_GAIN_SECOND: span_gain_second_ff <=
                            merge({8'h0, span_gain_second_ff}, wdata_ff, wstrb_ff)[23:0];
                    endcase
                end
            end
        end
    end

    // Read channel answers one cycle after the address is taken.
    wire [4:0] ridx = bus.araddr[6:2];
    logic [31:0] rmux;
    logic rok;
    always_comb begin
        rok = 1'b1;
        unique case (ridx)
            {1'b0, IDX_CFG0}: rmux = cfg0_ff;
            {1'b0, IDX_CFG2}: rmux = cfg2_ff;
            {1'b0, IDX_CFG8}: rmux = cfg8_ff;
            {1'b0, IDX_CFG10}: rmux = cfg10_ff;
            {1'b0, IDX_SPAN_GAIN_FIRST}: rmux = {8'h0, span_gain_first_ff};
            {1'b0, IDX_SPAN_GAIN_SECOND}: rmux = {8'h0, span_gain_second_ff};
            {1'b0, IDX_BRIDGE_OFFSET}: rmux = {8'h0, bridge_offset_value_ff};
            {1'b0, IDX_SCALE_FIRST}: rmux = {8'h0, scale_factor_first_ff};
            {1'b0, IDX_SCALE_SECOND}: rmux = {8'h0, scale_factor_second_ff};
            IDX_RES1: rmux = res_ff[0];
            IDX_RES2: rmux = res_ff[1];
            IDX_RES3: rmux = res_ff[2];
            IDX_RES4: rmux = res_ff[3];
            IDX_TEMP: rmux = temp_res_ff;
            IDX_STATUS: rmux = {30'h0, range_err_ff, busy};
            default: begin
                rmux = RESET_ZERO;
                rok = 1'b0;
            end
        endcase
    end
    assign bus.arready = !rvalid_ff;
    assign bus.rvalid = rvalid_ff;
    assign bus.rdata = rdata_ff;
    assign bus.rresp = rresp_ff;
    always_ff @(posedge aclk) begin
        if (!bus.aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= RESET_ZERO;
            rresp_ff <= RESP_OKAY;
        end else if (bus.arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rmux;
            rresp_ff <= rok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_ff && bus.rready) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/comp_pkg.sv */
package comp_pkg;
    // Register indices of the device-side map, byte address is index times four.
    localparam logic [3:0] IDX_CFG0 = 4'h0;
    localparam logic [3:0] IDX_CFG2 = 4'h2;
    localparam logic [3:0] IDX_CFG8 = 4'h8;
    localparam logic [3:0] IDX_CFG10 = 4'hA;
    localparam logic [3:0] IDX_SPAN_GAIN_FIRST = 4'hE;
    localparam logic [3:0] IDX_SPAN_GAIN_SECOND = 4'hF;
    // Registers placed in the free slots of the map.
    localparam logic [3:0] IDX_BRIDGE_OFFSET = 4'h3;
    localparam logic [3:0] IDX_SCALE_FIRST = 4'h4;
    localparam logic [3:0] IDX_SCALE_SECOND = 4'h5;
    localparam logic [3:0] IDX_RAW_HB1 = 4'h6;
    localparam logic [3:0] IDX_RAW_HB2 = 4'h7;
    localparam logic [3:0] IDX_RAW_HB3 = 4'h9;
    localparam logic [3:0] IDX_RAW_HB4 = 4'hB;
    localparam logic [3:0] IDX_RTEMP = 4'hC;
    localparam logic [3:0] IDX_RCOMP = 4'hD;
    localparam logic [3:0] IDX_START = 4'h1;
    // Result registers, read only.
    localparam logic [4:0] IDX_RES1 = 5'h10;
    localparam logic [4:0] IDX_RES2 = 5'h11;
    localparam logic [4:0] IDX_RES3 = 5'h12;
    localparam logic [4:0] IDX_RES4 = 5'h13;
    localparam logic [4:0] IDX_TEMP = 5'h14;
    localparam logic [4:0] IDX_STATUS = 5'h15;
    // Field positions.
    localparam int CFG0_SCALE_EN_BIT = 17;
    localparam int CFG0_CALAV_LO = 22;
    localparam int CFG8_SCALE2_EN_BIT = 0;
    localparam int CFG10_RSPAN_BIT = 0;
    localparam int CFG10_SPANBYT_BIT = 1;
    localparam int CFG10_SIGN1_BIT = 2;
    localparam int CFG10_SIGN2_BIT = 3;
    localparam int CFG10_DOUBLE_BIT = 4;
    localparam int CFG10_SUM_BIT = 5;
    localparam int CFG10_DIFF_BIT = 6;
    localparam int CFG10_OFFSUB_BIT = 7;
    localparam int CFG10_HS_REF_BIT = 8;
    localparam int CFG10_LOAD_START_BIT = 9;
    localparam int CFG10_LOAD_DEL_BIT = 10;
    localparam int CFG2_CALC_LO = 0;
    localparam int CFG8_RDSON_LO = 4;
    localparam int CFG8_GAINCOR_LO = 8;
    localparam int FRAC_BITS = 16;
    localparam int OFFS_FRAC_BITS = 8;
    localparam int RANGE1_BITS = 20;
    localparam logic [23:0] GAIN_ONE = 24'h010000;
    localparam logic [23:0] GAIN_HALF = 24'h008000;
    localparam logic [31:0] RESET_ZERO = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: hdl/comp_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface comp_if (
    input wire logic aclk
);
    logic aresetn;
    logic [6:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [6:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    modport device (
        input aresetn, awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
        output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
    );
    modport controller (
        output aresetn, awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
        input awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
    );
endinterface
`default_nettype wire

/* File: hdl/comp_controller.sv */
`timescale 1ns/100ps
`default_nettype none
module comp_controller
    import comp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    comp_if.controller bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic [6:0] cmd_addr,
    input wire logic [31:0] cmd_wdata,
    output logic done,
    output logic [31:0] rd_data,
    output logic [1:0] resp
);
    typedef enum logic [1:0] {IDLE, WR, RD} host_state_t;
    host_state_t state_ff;
    logic awv_ff, wv_ff, bready_ff, arv_ff, rready_ff, done_ff;
    logic [6:0] addr_ff;
    logic [31:0] wdata_ff, rd_data_ff;
    logic [1:0] resp_ff;

    // Calibration, coin cell and capacitance settings are the caller's job;
    // this end only moves the words it is told to move. [RQ10] [RQ17] [RQ20] [RQ21]
    assign bus.aresetn = aresetn;
    assign bus.awaddr = addr_ff;
    assign bus.araddr = addr_ff;
    assign bus.awvalid = awv_ff;
    assign bus.wvalid = wv_ff;
    assign bus.wdata = wdata_ff;
    assign bus.wstrb = 4'hF;
    assign bus.bready = bready_ff;
    assign bus.arvalid = arv_ff;
    assign bus.rready = rready_ff;
    assign cmd_ready = state_ff == IDLE;
    assign done = done_ff;
    assign rd_data = rd_data_ff;
    assign resp = resp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= IDLE;
            awv_ff <= 1'b0;
            wv_ff <= 1'b0;
            bready_ff <= 1'b0;
            arv_ff <= 1'b0;
            rready_ff <= 1'b0;
            done_ff <= 1'b0;
            addr_ff <= 7'h00;
            wdata_ff <= RESET_ZERO;
            rd_data_ff <= RESET_ZERO;
            resp_ff <= RESP_OKAY;
        end else begin
            done_ff <= 1'b0;
            unique case (state_ff)
                IDLE: if (cmd_valid) begin
                    addr_ff <= cmd_addr;
                    wdata_ff <= cmd_wdata;
                    if (cmd_write) begin
                        awv_ff <= 1'b1;
                        wv_ff <= 1'b1;
                        bready_ff <= 1'b1;
                        state_ff <= WR;
                    end else begin
                        arv_ff <= 1'b1;
                        rready_ff <= 1'b1;
                        state_ff <= RD;
                    end
                end
                WR: begin
                    if (bus.awready) awv_ff <= 1'b0;
                    if (bus.wready) wv_ff <= 1'b0;
                    if (bus.bvalid) begin
                        bready_ff <= 1'b0;
                        resp_ff <= bus.bresp;
                        done_ff <= 1'b1;
                        state_ff <= IDLE;
                    end
                end
                RD: begin
                    if (bus.arready) arv_ff <= 1'b0;
                    if (bus.rvalid) begin
                        rready_ff <= 1'b0;
                        rd_data_ff <= bus.rdata;
                        resp_ff <= bus.rresp;
                        done_ff <= 1'b1;
                        state_ff <= IDLE;
                    end
                end
                default: state_ff <= IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: testbench/comp_props.sv */
`timescale 1ns/100ps
`default_nettype none
module comp_props
    import comp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [6:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [6:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_aw_held: assert property (awvalid && !awready |=> awvalid && $stable(awaddr))
        else $error("write address dropped before it was taken");
    chk_w_held: assert property (wvalid && !wready |=> wvalid)
        else $error("write data dropped before it was taken");
    chk_ar_held: assert property (arvalid && !arready |=> arvalid && $stable(araddr))
        else $error("read address dropped before it was taken");
    chk_write_answer: assert property (
        awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write response late");
    chk_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read data not one cycle after address");
    chk_write_once: assert property (bvalid && bready |=> !bvalid)
        else $error("second write response without request");
    chk_read_once: assert property (rvalid && rready |=> !rvalid)
        else $error("second read answer without request");
    chk_gain_width: assert property (arvalid && arready && araddr[6:3] == 4'h7
        |=> rdata[31:24] == 8'h00)
        else $error("span gain wider than 24 bits");
    chk_scale_width: assert property (arvalid && arready && araddr[6:3] == 4'h2
        |=> rdata[31:24] == 8'h00)
        else $error("scale factor wider than 24 bits");
    chk_unmapped_write: assert property (awvalid && awready && awaddr[6]
        |-> ##[1:4] (bvalid && bresp == RESP_SLVERR))
        else $error("write to result space not refused");
    chk_unmapped_read: assert property (arvalid && arready && araddr[6:2] > 5'h15
        |=> rvalid && rresp == RESP_SLVERR && rdata == 32'h00000000)
        else $error("unmapped read not refused with zero data");
endmodule
`default_nettype wire

/* File: testbench/bridge_result_compensation_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module bridge_result_compensation_tb_top
    import comp_pkg::*;
;
    logic aclk, aresetn, cmd_valid, cmd_ready, cmd_write, done;
    logic [6:0] cmd_addr;
    logic [31:0] cmd_wdata, rd_data;
    logic [1:0] resp;
    logic cyc_ref, ld_start, ld_del, busy;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    comp_if comp_if_inst (.aclk(aclk));
    comp_controller comp_controller_inst (.aclk(aclk), .aresetn(aresetn), .bus(comp_if_inst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .done(done), .rd_data(rd_data),
        .resp(resp));
    comp_device comp_device_inst (.aclk(aclk), .bus(comp_if_inst),
        .cycle_reference_select(cyc_ref), .load_start_bit(ld_start),
        .load_start_delay_bit(ld_del), .busy(busy));
    comp_props comp_props_inst (.aclk(aclk), .aresetn(comp_if_inst.aresetn),
        .awaddr(comp_if_inst.awaddr), .awvalid(comp_if_inst.awvalid),
        .awready(comp_if_inst.awready), .wvalid(comp_if_inst.wvalid),
        .wready(comp_if_inst.wready), .bresp(comp_if_inst.bresp),
        .bvalid(comp_if_inst.bvalid), .bready(comp_if_inst.bready),
        .araddr(comp_if_inst.araddr), .arvalid(comp_if_inst.arvalid),
        .arready(comp_if_inst.arready), .rdata(comp_if_inst.rdata),
        .rresp(comp_if_inst.rresp), .rvalid(comp_if_inst.rvalid),
        .rready(comp_if_inst.rready));
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One command at a time: the controller only takes a new one after done.
    task automatic access(input logic wr_en, input logic [6:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge aclk);
        cmd_valid <= 1'b1;
        cmd_write <= wr_en;
        cmd_addr <= addr;
        cmd_wdata <= data;
        @(posedge aclk);
        cmd_valid <= 1'b0;
        do begin
            @(posedge aclk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 200);
        if (done !== 1'b1) mismatches++;
    endtask
    task automatic wr(input logic [6:0] addr, input logic [31:0] data);
        access(1'b1, addr, data);
    endtask
    task automatic rdc(input logic [6:0] addr, input logic [31:0] exp);
        access(1'b0, addr, 32'h00000000);
        check(rd_data, exp);
    endtask
    // Results land two cycles after start; busy bounds any longer calculation.
    task automatic calc();
        int n;
        n = 0;
        wr(7'h04, 32'h00000001);
        repeat (3) @(posedge aclk);
        #1;
        while (busy !== 1'b0 && n < 100) begin
            @(posedge aclk);
            #1;
            n++;
        end
        if (busy !== 1'b0) mismatches++;
    endtask
    initial begin
        aresetn = 1'b0;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 7'h00;
        cmd_wdata = 32'h00000000;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(7'h38, 32'h00010000);
        rdc(7'h3C, 32'h00010000);
        rdc(7'h10, 32'h00010000);
        rdc(7'h14, 32'h00010000);
        rdc(7'h0C, 32'h00000000);
        wr(7'h38, 32'hFFFFFFFF);
        rdc(7'h38, 32'h00FFFFFF);
        wr(7'h3C, 32'h00000000);
        rdc(7'h3C, 32'h00000000);
        wr(7'h0C, 32'h00123456);
        rdc(7'h0C, 32'h00123456);
        access(1'b0, 7'h7C, 32'h00000000);
        check({30'h0, resp}, {30'h0, RESP_SLVERR});
        check(rd_data, 32'h00000000);
        access(1'b1, 7'h40, 32'h00000005);
        check({30'h0, resp}, {30'h0, RESP_SLVERR});
        for (int i = 0; i < 3; i++) begin
            wr(7'h28, 32'h00000100 << i);
            check({29'h0, ld_del, ld_start, cyc_ref}, 32'h00000001 << i);
        end
        wr(7'h18, 32'h00001000);
        wr(7'h1C, 32'h00002000);
        wr(7'h10, {8'h00, GAIN_HALF});
        wr(7'h14, 32'h00020000);
        wr(7'h00, 32'h00020000);
        wr(7'h20, 32'h00000001);
        wr(7'h28, 32'h00000000);
        calc();
        rdc(7'h40, 32'h00000800);
        rdc(7'h44, 32'h00004000);
        wr(7'h00, 32'h00000000);
        wr(7'h20, 32'h00000000);
        calc();
        rdc(7'h40, 32'h00001000);
        rdc(7'h44, 32'h00002000);
        wr(7'h18, 32'h00180000);
        calc();
        access(1'b0, 7'h54, 32'h00000000);
        check({31'h0, rd_data[1]}, 32'h00000001);
        // Fullbridge span by resistor: 0.5 * 0x1000 + 2.0 * 0x2000, then times 1.5.
        wr(7'h08, 32'h00000001);
        wr(7'h00, 32'h00020000);
        wr(7'h20, 32'h00000011);
        wr(7'h18, 32'h00001000);
        wr(7'h34, 32'h00008000);
        wr(7'h38, 32'h00010000);
        wr(7'h28, 32'h00000621);
        calc();
        rdc(7'h40, 32'h00006C00);
        rdc(7'h50, 32'h00018000);
        check({30'h0, ld_del, ld_start}, 32'h00000003);
        wr(7'h28, 32'h000000A5);
        calc();
        rdc(7'h40, 32'h000011CC);
        wr(7'h30, 32'h00004000);
        wr(7'h28, 32'h00000023);
        calc();
        rdc(7'h40, 32'h00005A00);
        rdc(7'h50, 32'h00004000);
        wr(7'h38, 32'h00000000);
        wr(7'h28, 32'h00000021);
        calc();
        rdc(7'h40, 32'h00004800);
        wr(7'h3C, 32'h00010000);
        wr(7'h24, 32'h00000100);
        wr(7'h2C, 32'h00000200);
        wr(7'h28, 32'h00000031);
        calc();
        rdc(7'h40, 32'h00001800);
        rdc(7'h44, 32'h00000900);
        wr(7'h28, 32'h00000010);
        calc();
        rdc(7'h44, 32'h00001000);
        rdc(7'h4C, 32'h00000400);
        // Offset calibration: measure with neutral span, then subtract the stored ppm.
        wr(7'h14, {8'h00, GAIN_HALF});
        wr(7'h28, 32'h00000021);
        calc();
        rdc(7'h40, 32'h00001800);
        wr(7'h0C, 32'h00180000);
        wr(7'h28, 32'h000000A1);
        calc();
        rdc(7'h40, 32'h00000000);
        end_sim();
    end
endmodule
`default_nettype wire
